// File: rtl/fse_status_regs.sv
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`include "fse_defs.svh"
module fse_status_regs
	import fse_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire fse_evt_t evt,
	output logic cmd_launch,
	output logic seq_allowed,
	output logic cmd_irq,
	output logic err_irq
);
	logic wr_stb;
	logic rd_stb;
	logic pready_int;
	logic [11:0] acc_addr;
	logic [7:0] wbyte;
	logic wr_en_reg;
	logic wr_cfg;
	logic wr_stat;
	logic wr_err;
	logic [1:0] en_reg;
	logic done_irq_en_reg;
	logic ign_single_reg;
	logic cmd_done_reg;
	logic busy_reg;
	logic [1:0] compl_status_reg;
	logic wr_fire;
	logic [1:0] prot_set;
	logic [1:0] prot_clr;
	logic [1:0] prot_flags;
	logic [1:0] fault_set;
	logic [1:0] fault_clr;
	logic [1:0] fault_flags;
	logic launch_next;
	logic mapped;
	logic [7:0] rd_byte;

	fse_apb_slave u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.acc_addr(acc_addr),
		.pready_int(pready_int)
	);

	always_comb begin
		wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
		// a write lands at the edge where the master samples pready, not one edge earlier
		wr_fire = pready && psel && penable && pwrite;
		wr_en_reg = wr_fire && pstrb[0] && (acc_addr == `FSE_ADDR_ERR_IRQ_EN);
		wr_cfg = wr_fire && pstrb[0] && (acc_addr == `FSE_ADDR_CONFIG);
		wr_stat = wr_fire && pstrb[0] && (acc_addr == `FSE_ADDR_CMD_STATUS);
		wr_err = wr_fire && pstrb[0] && (acc_addr == `FSE_ADDR_ERR_STATUS);
		mapped = (acc_addr == `FSE_ADDR_ERR_IRQ_EN) || (acc_addr == `FSE_ADDR_CMD_STATUS) ||
			(acc_addr == `FSE_ADDR_ERR_STATUS) || (acc_addr == `FSE_ADDR_CONFIG);
	end

	// error interrupt enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_reg <= 2'(`FSE_RST_ERR_IRQ_EN);
		end else if (wr_en_reg) begin
			en_reg <= wbyte[1:0];
		end
	end

	// configuration bits this block consumes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_irq_en_reg <= 1'b0;
			ign_single_reg <= 1'b0;
		end else if (wr_cfg) begin
			done_irq_en_reg <= wbyte[`FSE_BIT_DONE_IRQ_EN];
			ign_single_reg <= wbyte[`FSE_BIT_IGN_SGL];
		end
	end

	// launch only when neither the access error nor the protection violation flag blocks it
	always_comb begin
		launch_next = wr_stat && wbyte[`FSE_BIT_CMD_DONE] && cmd_done_reg &&
			!prot_flags[1] && !prot_flags[0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_launch <= 1'b0;
		end else begin
			cmd_launch <= launch_next;
		end
	end

	// command complete and busy
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_done_reg <= 1'b1;
			busy_reg <= 1'b0;
		end else if (launch_next) begin
			cmd_done_reg <= 1'b0;
			busy_reg <= 1'b1;
		end else if (!cmd_done_reg && (evt.cmd_done || evt.cmd_violation)) begin
			cmd_done_reg <= 1'b1;
			busy_reg <= 1'b0;
		end
	end

	// completion status follows the sequencer, including the reset sequence result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			compl_status_reg <= 2'b00;
		end else if (launch_next) begin
			compl_status_reg <= 2'b00;
		end else if (evt.compl_status_load) begin
			compl_status_reg <= evt.compl_status;
		end
	end

	// index 1 access error, index 0 protection violation
	always_comb begin
		prot_set[1] = evt.cmd_violation || evt.illegal_cmd;
		prot_set[0] = evt.prot_violation;
		prot_clr[1] = wr_stat && wbyte[`FSE_BIT_ACC_ERR];
		prot_clr[0] = wr_stat && wbyte[`FSE_BIT_PROT_VIOL];
	end

	fse_w1c_flag #(.WIDTH(2)) u_cmd_err (
		.pclk(pclk),
		.presetn(presetn),
		.set_in(prot_set),
		.clr_in(prot_clr),
		.flag(prot_flags)
	);

	// a collision sets both flags; an ecc fault sets at most one
	always_comb begin
		fault_set[1] = evt.read_collision || evt.double_fault;
		fault_set[0] = evt.read_collision ||
			(evt.single_fault && !evt.double_fault && !ign_single_reg);
		fault_clr[1] = wr_err && wbyte[`FSE_BIT_DFF];
		fault_clr[0] = wr_err && wbyte[`FSE_BIT_SFF];
	end

	fse_w1c_flag #(.WIDTH(2)) u_fault (
		.pclk(pclk),
		.presetn(presetn),
		.set_in(fault_set),
		.clr_in(fault_clr),
		.flag(fault_flags)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seq_allowed <= 1'b1;
		end else begin
			seq_allowed <= !prot_flags[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_irq <= 1'b0;
			cmd_irq <= 1'b0;
		end else begin
			err_irq <= (fault_flags[1] && en_reg[`FSE_BIT_DBL_IRQ_EN]) ||
				(fault_flags[0] && en_reg[`FSE_BIT_SGL_IRQ_EN]);
			cmd_irq <= cmd_done_reg && done_irq_en_reg;
		end
	end

	// read mux; unused bits read zero
	always_comb begin
		rd_byte = 8'h00;
		case (acc_addr)
			`FSE_ADDR_ERR_IRQ_EN: rd_byte = {6'h00, en_reg};
			`FSE_ADDR_CONFIG: rd_byte = {done_irq_en_reg, 2'b00, ign_single_reg, 4'h0};
			`FSE_ADDR_CMD_STATUS: rd_byte = {cmd_done_reg, 1'b0, prot_flags, busy_reg, 1'b0,
				compl_status_reg};
			`FSE_ADDR_ERR_STATUS: rd_byte = {6'h00, fault_flags};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
			if (psel && penable && !pready && !pready_int && !wr_stb && !rd_stb) begin
				pready <= 1'b0;
			end
			if (pready_int && psel && penable) begin
				pready <= 1'b0;
			end
			if (psel && penable && !pready && pready_int) begin
				pready <= 1'b1;
				prdata <= {24'h000000, rd_byte};
				pslverr <= !mapped;
			end
		end
	end

	chk_launch_lowers: assert property (@(posedge pclk) disable iff (!presetn)
		launch_next |=> !cmd_done_reg && busy_reg) else $error("launch did not lower complete");
	chk_acc_err_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		prot_flags[1] |-> !launch_next) else $error("launch while access error");
	chk_viol_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		prot_flags[0] |=> !seq_allowed) else $error("sequence allowed in violation");
	chk_launch_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		launch_next |=> cmd_launch) else $error("launch pulse missing");
	chk_no_relaunch: assert property (@(posedge pclk) disable iff (!presetn)
		!cmd_done_reg |-> !launch_next) else $error("launch while command runs");
	chk_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
		!cmd_done_reg && (evt.cmd_done || evt.cmd_violation) |=> cmd_done_reg)
		else $error("complete flag not set");
	chk_acc_err_set: assert property (@(posedge pclk) disable iff (!presetn)
		evt.illegal_cmd || evt.cmd_violation |=> prot_flags[1]) else $error("access error missed");
	chk_viol_set: assert property (@(posedge pclk) disable iff (!presetn)
		evt.prot_violation |=> prot_flags[0]) else $error("protection violation missed");
	chk_viol_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		prot_flags[0] && !prot_clr[0] |=> prot_flags[0]) else $error("violation lost");
	chk_viol_no_launch: assert property (@(posedge pclk) disable iff (!presetn)
		prot_flags[0] |-> !launch_next) else $error("launch in violation");
	chk_seq_free: assert property (@(posedge pclk) disable iff (!presetn)
		!prot_flags[0] |=> seq_allowed) else $error("sequence blocked without violation");
	chk_busy_idle: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_done_reg |-> !busy_reg) else $error("busy while idle");
	chk_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
		launch_next |=> compl_status_reg == 2'b00) else $error("status not cleared");
	chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
		acc_addr == `FSE_ADDR_CMD_STATUS |-> !rd_byte[6] && !rd_byte[2])
		else $error("reserved status bit set");
	chk_irq_en_store: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en_reg |=> en_reg == $past(wbyte[1:0])) else $error("enable not stored");
	chk_dbl_set: assert property (@(posedge pclk) disable iff (!presetn)
		evt.double_fault |=> fault_flags[1]) else $error("double fault missed");
	chk_dbl_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		fault_flags[1] && !fault_clr[1] |=> fault_flags[1]) else $error("double flag lost");
	chk_sgl_set: assert property (@(posedge pclk) disable iff (!presetn)
		evt.single_fault && !evt.double_fault && !ign_single_reg |=> fault_flags[0])
		else $error("single fault missed");
	chk_sgl_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		fault_flags[0] && !fault_clr[0] |=> fault_flags[0]) else $error("single flag lost");
	chk_ecc_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
		evt.double_fault && !evt.read_collision && !fault_flags[0] |=> !fault_flags[0])
		else $error("ecc fault set both flags");
	chk_sgl_irq: assert property (@(posedge pclk) disable iff (!presetn)
		fault_flags[0] && en_reg[0] |=> err_irq) else $error("single irq missing");
	chk_done_irq: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_done_reg && done_irq_en_reg |=> cmd_irq) else $error("complete irq missing");
	chk_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready) else $error("pready longer than one cycle");
	chk_collision_both: assert property (@(posedge pclk) disable iff (!presetn)
		evt.read_collision |=> fault_flags == 2'b11) else $error("collision not both");
	chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		fault_set[1] && fault_clr[1] |=> fault_flags[1]) else $error("set lost");
	chk_ign_single_hold: assert property (@(posedge pclk) disable iff (!presetn)
		ign_single_reg && !fault_flags[0] && !evt.read_collision |=> !fault_flags[0])
		else $error("single fault reported while ignored");
	chk_err_irq_dbl: assert property (@(posedge pclk) disable iff (!presetn)
		fault_flags[1] && en_reg[1] |=> err_irq) else $error("double irq missing");
	chk_err_irq_none: assert property (@(posedge pclk) disable iff (!presetn)
		en_reg == 2'b00 |=> !err_irq) else $error("irq while disabled");
	chk_busy_done: assert property (@(posedge pclk) disable iff (!presetn)
		busy_reg |-> !cmd_done_reg) else $error("busy with complete high");
	chk_acc_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		prot_flags[1] && !prot_clr[1] |=> prot_flags[1]) else $error("access error lost");

	cov_launch: cover property (@(posedge pclk) disable iff (!presetn) launch_next);
	cov_collision: cover property (@(posedge pclk) disable iff (!presetn) evt.read_collision);
	cov_blocked: cover property (@(posedge pclk) disable iff (!presetn)
		wr_stat && wbyte[7] && prot_flags != 2'b00);
	cov_done_irq: cover property (@(posedge pclk) disable iff (!presetn)
		cmd_done_reg && done_irq_en_reg && cmd_irq);
endmodule // fse_status_regs

// File: common/fse_defs.svh
`ifndef FSE_DEFS_SVH
`define FSE_DEFS_SVH

// register indices; byte address is four times the index
`define FSE_IDX_ERR_IRQ_EN 12'h105
`define FSE_IDX_CMD_STATUS 12'h106
`define FSE_IDX_ERR_STATUS 12'h107
`define FSE_IDX_CONFIG 12'h104
`define FSE_ADDR_ERR_IRQ_EN 12'h414
`define FSE_ADDR_CMD_STATUS 12'h418
`define FSE_ADDR_ERR_STATUS 12'h41C
`define FSE_ADDR_CONFIG 12'h410

`define FSE_BIT_DBL_IRQ_EN 1
`define FSE_BIT_SGL_IRQ_EN 0
`define FSE_BIT_CMD_DONE 7
`define FSE_BIT_ACC_ERR 5
`define FSE_BIT_PROT_VIOL 4
`define FSE_BIT_BUSY 3
`define FSE_BIT_DONE_IRQ_EN 7
`define FSE_BIT_IGN_SGL 4
`define FSE_BIT_DFF 1
`define FSE_BIT_SFF 0

`define FSE_RST_ERR_IRQ_EN 8'h00
`define FSE_RST_CMD_STATUS 8'h80
`define FSE_RST_ERR_STATUS 8'h00
`define FSE_RST_CONFIG 8'h00

`endif

// File: common/fse_pkg.sv
package fse_pkg;
	// events from the command sequencer and array read path
	typedef struct packed {
		logic cmd_done;
		logic cmd_violation;
		logic illegal_cmd;
		logic prot_violation;
		logic seq_start;
		logic single_fault;
		logic double_fault;
		logic read_collision;
		logic [1:0] compl_status;
		logic compl_status_load;
	} fse_evt_t;

	typedef enum logic [2:0] {
		FSE_IDLE = 3'b001,
		FSE_ACCESS = 3'b010,
		FSE_DONE = 3'b100
	} fse_apb_st_t;
endpackage

// File: rtl/fse_apb_slave.sv
`timescale 1ns/10ps
`include "fse_defs.svh"
module fse_apb_slave
	import fse_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	output logic wr_stb,
	output logic rd_stb,
	output logic [11:0] acc_addr,
	output logic pready_int
);
	fse_apb_st_t st_reg;

	// two wait states on pready: request taken in access phase, pready_int the next cycle, pready registered one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= FSE_IDLE;
		end else begin
			case (st_reg)
				FSE_IDLE: begin
					if (psel && penable) begin
						st_reg <= FSE_DONE;
					end
				end
				FSE_DONE: begin
					// move to ACCESS and park there until the master drops the access, so one access is taken once
					if (psel && penable) begin
						st_reg <= FSE_ACCESS;
					end else begin
						st_reg <= FSE_IDLE;
					end
				end
				FSE_ACCESS: begin
					if (!(psel && penable)) begin
						st_reg <= FSE_IDLE;
					end
				end
				default: begin
					st_reg <= FSE_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_addr <= 12'h000;
		end else if (st_reg == FSE_IDLE && psel && penable) begin
			acc_addr <= paddr;
		end
	end

	always_comb begin
		pready_int = (st_reg == FSE_DONE);
		wr_stb = pready_int && psel && penable && pwrite;
		rd_stb = pready_int && psel && penable && !pwrite;
	end
endmodule // fse_apb_slave

// File: rtl/fse_w1c_flag.sv
`timescale 1ns/10ps
module fse_w1c_flag #(
	parameter int WIDTH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	output logic [WIDTH-1:0] flag
);
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_flag
			// set has priority so an event in the clearing cycle survives
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					flag[gi] <= 1'b0;
				end else if (set_in[gi]) begin
					flag[gi] <= 1'b1;
				end else if (clr_in[gi]) begin
					flag[gi] <= 1'b0;
				end
			end
		end
	endgenerate
endmodule // fse_w1c_flag

// File: tb/tb_top.sv
`timescale 1ns/10ps
`include "fse_defs.svh"
module tb_top
	import fse_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	fse_evt_t evt = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cmd_launch;
	logic seq_allowed;
	logic cmd_irq;
	logic err_irq;
	int failures = 0;
	int compares = 0;
	int n_launch = 0;
	logic [31:0] rng = 32'h5C41F752;
	logic [31:0] q;
	logic serr;
	logic [7:0] m_st;
	logic [1:0] c;
	fse_evt_t e;
	int n0;

	fse_status_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .evt(evt), .cmd_launch(cmd_launch),
		.seq_allowed(seq_allowed), .cmd_irq(cmd_irq), .err_irq(err_irq));

	always #5 pclk = ~pclk;

	// launch is a one-cycle pulse, so count it at every edge
	always @(posedge pclk) begin
		if (cmd_launch === 1'b1) n_launch++;
	end

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic finish_test();
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// entered just after a rising edge; leaves two idle edges before returning
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		penable <= 1'b0;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			failures++;
			$display("Error pready never seen");
		end
		q = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// two edges so the lagging level outputs have settled before any check
		repeat (2) @(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {rnd() & 32'hFFFFFF00} | {24'h000000, d});
	endtask

	task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] ex);
		apb(1'b0, a, rnd());
		chk(nm, {24'h000000, ex}, q);
	endtask

	task automatic pulse(input fse_evt_t ev);
		evt <= ev;
		@(posedge pclk);
		evt <= '0;
		repeat (2) @(posedge pclk);
	endtask

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd("cmd_status_rst", `FSE_ADDR_CMD_STATUS, 8'h80);
		rd("irq_en_rst", `FSE_ADDR_ERR_IRQ_EN, 8'h00);
		rd("err_status_rst", `FSE_ADDR_ERR_STATUS, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(`FSE_ADDR_ERR_IRQ_EN, i[7:0]);
			rd("irq_en", `FSE_ADDR_ERR_IRQ_EN, i[7:0]);
			e = '0;
			e.double_fault = 1'b1;
			pulse(e);
			rd("dff_set", `FSE_ADDR_ERR_STATUS, 8'h02);
			chk("err_irq_dff", {31'h0, i[1]}, {31'h0, err_irq});
			wr(`FSE_ADDR_ERR_STATUS, 8'h00);
			rd("dff_w0", `FSE_ADDR_ERR_STATUS, 8'h02);
			e = '0;
			e.single_fault = 1'b1;
			pulse(e);
			rd("sff_set", `FSE_ADDR_ERR_STATUS, 8'h03);
			chk("err_irq_both", {31'h0, i[1] | i[0]}, {31'h0, err_irq});
			wr(`FSE_ADDR_ERR_STATUS, 8'h02);
			rd("dff_w1c", `FSE_ADDR_ERR_STATUS, 8'h01);
			chk("err_irq_sff", {31'h0, i[0]}, {31'h0, err_irq});
			wr(`FSE_ADDR_ERR_STATUS, 8'h01);
			rd("sff_w1c", `FSE_ADDR_ERR_STATUS, 8'h00);
			chk("err_irq_clr", 32'h0, {31'h0, err_irq});
		end
		pstrb <= 4'hE;
		wr(`FSE_ADDR_ERR_IRQ_EN, 8'h00);
		pstrb <= 4'hF;
		rd("strb_ignored", `FSE_ADDR_ERR_IRQ_EN, 8'h03);
		e = '0;
		e.read_collision = 1'b1;
		pulse(e);
		rd("collision", `FSE_ADDR_ERR_STATUS, 8'h03);
		e = '0;
		e.single_fault = 1'b1;
		e.double_fault = 1'b1;
		wr(`FSE_ADDR_ERR_STATUS, 8'h03);
		pulse(e);
		rd("ecc_exclusive", `FSE_ADDR_ERR_STATUS, 8'h02);
		wr(`FSE_ADDR_ERR_STATUS, 8'h03);
		wr(`FSE_ADDR_CONFIG, 8'h10);
		e = '0;
		e.single_fault = 1'b1;
		pulse(e);
		rd("sff_ignored", `FSE_ADDR_ERR_STATUS, 8'h00);
		chk("err_irq_ignored", 32'h0, {31'h0, err_irq});
		wr(`FSE_ADDR_CONFIG, 8'h80);
		chk("cmd_irq_idle", 32'h1, {31'h0, cmd_irq});
		// reserved and read-only bits are written as ones to show they are ignored
		n0 = n_launch;
		wr(`FSE_ADDR_CMD_STATUS, 8'hCF);
		chk("launch", 32'h1, n_launch - n0);
		rd("busy", `FSE_ADDR_CMD_STATUS, 8'h08);
		chk("cmd_irq_busy", 32'h0, {31'h0, cmd_irq});
		q = rnd();
		c = q[1:0];
		e = '0;
		e.cmd_done = 1'b1;
		e.compl_status = c;
		e.compl_status_load = 1'b1;
		pulse(e);
		m_st = {6'h20, c};
		rd("done", `FSE_ADDR_CMD_STATUS, m_st);
		e = '0;
		e.illegal_cmd = 1'b1;
		pulse(e);
		m_st = m_st | 8'h20;
		rd("acc_err", `FSE_ADDR_CMD_STATUS, m_st);
		n0 = n_launch;
		wr(`FSE_ADDR_CMD_STATUS, 8'h80);
		chk("acc_no_launch", 32'h0, n_launch - n0);
		rd("acc_hold", `FSE_ADDR_CMD_STATUS, m_st);
		wr(`FSE_ADDR_CMD_STATUS, 8'h00);
		rd("acc_w0", `FSE_ADDR_CMD_STATUS, m_st);
		wr(`FSE_ADDR_CMD_STATUS, 8'h20);
		rd("acc_w1c", `FSE_ADDR_CMD_STATUS, m_st & 8'hDF);
		wr(`FSE_ADDR_CMD_STATUS, 8'h80);
		e = '0;
		e.cmd_violation = 1'b1;
		pulse(e);
		rd("violation", `FSE_ADDR_CMD_STATUS, 8'hA0);
		wr(`FSE_ADDR_CMD_STATUS, 8'h20);
		e = '0;
		e.prot_violation = 1'b1;
		pulse(e);
		rd("prot_set", `FSE_ADDR_CMD_STATUS, 8'h90);
		chk("seq_blocked", 32'h0, {31'h0, seq_allowed});
		n0 = n_launch;
		wr(`FSE_ADDR_CMD_STATUS, 8'h80);
		chk("prot_no_launch", 32'h0, n_launch - n0);
		wr(`FSE_ADDR_CMD_STATUS, 8'h00);
		rd("prot_w0", `FSE_ADDR_CMD_STATUS, 8'h90);
		wr(`FSE_ADDR_CMD_STATUS, 8'h10);
		rd("prot_w1c", `FSE_ADDR_CMD_STATUS, 8'h80);
		chk("seq_free", 32'h1, {31'h0, seq_allowed});
		apb(1'b0, 12'h420, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, serr});
		chk("unmapped_data", 32'h0, q);
		finish_test();
	end

	initial begin
		#200000;
		failures++;
		$display("Error watchdog expired");
		finish_test();
	end
endmodule // tb_top
